// ### src/power_event_ctrl.sv
// Power button, ring indicate, throttle and performance state control.
// Assumes sysState comes from the sleep machine on mclk; pins are async.
`timescale 1ns/1ps
`default_nettype none

module power_event_ctrl
  import pwr_event_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
  parameter logic [CNT_W-1:0] OVERRIDE_CYCLES = CNT_W'(OVERRIDE_CYC)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sleep machine
  input wire sys_state_t sysState,
  // Pins
  input wire logic powerButtonN,
  input wire logic ringIndicateN,
  input wire logic powerOk,
  input wire logic regulatorGood,
  // Processor and regulator side
  output logic stopClockN,
  output logic cpuPerformanceSelect,
  output logic voltageMuxSelect,
  output logic cpuPowerGood,
  // Events to the sleep machine and interrupt logic
  output logic wakeEvent,
  output logic smiEvent,
  output logic sciEvent,
  output logic forceS5,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] btnSync;
    logic btnSamp;
    logic [CNT_W-1:0] dbCnt;
    logic btnDb;
    logic [CNT_W-1:0] ovCnt;
    logic ovDone;
    logic [2:0] riSync;
    logic riLvl;
    logic [2:0] pokSync;
    logic pokLvl;
    logic [2:0] vgSync;
    logic vgLvl;
    logic [THR_W-1:0] thrCnt;
    logic stopClkN;
    logic throttleEnable;
    logic [DUTY_W-1:0] throttleDuty;
    logic perfHigh;
    logic sciRoutingEnable;
    logic ringWakeEnable;
    logic perfSel;
    logic muxSel;
    logic [HOLD_W-1:0] holdCnt;
    logic pwrGood;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic irqOut;
    logic wake;
    logic smi;
    logic sci;
    logic s5;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;

  logic [CNT_W-1:0] dbLimit;
  logic [THR_W-1:0] dutyCycles;
  assign dbLimit = DEBOUNCE_CYCLES;
  assign dutyCycles = THR_W'(nxtDutyWidth(cur_ff.throttleDuty));

  function automatic logic [THR_W-1:0] nxtDutyWidth(input logic [DUTY_W-1:0] duty);
    nxtDutyWidth = THR_W'(duty) * THR_STEP;
  endfunction : nxtDutyWidth

  always_comb begin
    logic access;
    logic wrCtrl;
    logic wrMask;
    logic rdStatus;
    logic pressEdge;
    logic riEdge;
    logic asleep;
    logic [EV_W-1:0] evSet;
    logic [EV_W-1:0] nxtStatus;
    access = 1'b0;
    wrCtrl = 1'b0;
    wrMask = 1'b0;
    rdStatus = 1'b0;
    pressEdge = 1'b0;
    riEdge = 1'b0;
    asleep = 1'b0;
    evSet = '0;
    nxtStatus = '0;
    nxt_ff = cur_ff;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Three stages; the sampled level moves only when stages two and three agree
    nxt_ff.btnSync = {cur_ff.btnSync[1:0], ~powerButtonN};
    if (cur_ff.btnSync[1] == cur_ff.btnSync[2]) begin
      nxt_ff.btnSamp = cur_ff.btnSync[2];
    end
    nxt_ff.riSync = {cur_ff.riSync[1:0], ~ringIndicateN};
    if (cur_ff.riSync[1] == cur_ff.riSync[2]) begin
      nxt_ff.riLvl = cur_ff.riSync[2];
    end
    // Power ok and regulator good are async too, same filter
    nxt_ff.pokSync = {cur_ff.pokSync[1:0], powerOk};
    if (cur_ff.pokSync[1] == cur_ff.pokSync[2]) begin
      nxt_ff.pokLvl = cur_ff.pokSync[2];
    end
    nxt_ff.vgSync = {cur_ff.vgSync[1:0], regulatorGood};
    if (cur_ff.vgSync[1] == cur_ff.vgSync[2]) begin
      nxt_ff.vgLvl = cur_ff.vgSync[2];
    end

    // ----------------------------------------------------------------
    // Sleep state decode
    // ----------------------------------------------------------------
    // G3 is neither awake nor asleep, so nothing can wake from it
    case (sysState)
      ST_S1M, ST_S3, ST_S4, ST_S5: begin
        asleep = 1'b1;
      end
      ST_S0, ST_G3: begin
        asleep = 1'b0;
      end
      default: begin
        // Unused codes never raise a wake
        asleep = 1'b0;
      end
    endcase

    // ----------------------------------------------------------------
    // Power button debounce
    // ----------------------------------------------------------------
    // 16 ms stable level
    if (cur_ff.btnSamp == cur_ff.btnDb) begin
      nxt_ff.dbCnt = '0;
    end else if (cur_ff.dbCnt >= dbLimit - CNT_W'(1)) begin
      nxt_ff.dbCnt = '0;
      nxt_ff.btnDb = cur_ff.btnSamp;
    end else begin
      nxt_ff.dbCnt = cur_ff.dbCnt + CNT_W'(1);
    end
    if (sysState == ST_G3) begin
      nxt_ff.btnDb = 1'b0;
      nxt_ff.dbCnt = '0;
    end
    pressEdge = nxt_ff.btnDb && !cur_ff.btnDb;

    // ----------------------------------------------------------------
    // Button events
    // ----------------------------------------------------------------
    nxt_ff.wake = 1'b0;
    nxt_ff.smi = 1'b0;
    nxt_ff.sci = 1'b0;
    nxt_ff.s5 = 1'b0;
    if (pressEdge) begin
      evSet[EV_BUTTON] = 1'b1;
      if (sysState == ST_S0) begin
        nxt_ff.sci = cur_ff.sciRoutingEnable;
        nxt_ff.smi = !cur_ff.sciRoutingEnable;
      end
      if (asleep) begin
        nxt_ff.wake = 1'b1;
      end
    end

    if (!cur_ff.btnDb || sysState != ST_S0) begin
      nxt_ff.ovCnt = '0;
      nxt_ff.ovDone = 1'b0;
    end else if (!cur_ff.ovDone) begin
      // Done flag stops a second pulse while still held
      if (cur_ff.ovCnt >= OVERRIDE_CYCLES - CNT_W'(1)) begin
        nxt_ff.s5 = 1'b1;
        nxt_ff.ovDone = 1'b1;
        evSet[EV_OVERRIDE] = 1'b1;
      end else begin
        nxt_ff.ovCnt = cur_ff.ovCnt + CNT_W'(1);
      end
    end

    // ----------------------------------------------------------------
    // Ring indicate
    // ----------------------------------------------------------------
    // Edge only: a ring held active wakes once
    riEdge = nxt_ff.riLvl && !cur_ff.riLvl;
    if (riEdge) begin
      if (sysState == ST_S0) begin
        evSet[EV_RING_BREAK] = 1'b1;
      end
      if (asleep && cur_ff.ringWakeEnable) begin
        evSet[EV_RING_WAKE] = 1'b1;
        nxt_ff.wake = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Throttle
    // ----------------------------------------------------------------
    // Free-running period: a new duty lands mid-period
    nxt_ff.thrCnt = cur_ff.thrCnt + THR_W'(1);
    nxt_ff.stopClkN = !(cur_ff.throttleEnable && (sysState == ST_S0) &&
                        (cur_ff.thrCnt < dutyCycles));

    // ----------------------------------------------------------------
    // Performance state and processor power good
    // ----------------------------------------------------------------
    // Follows software directly
    nxt_ff.perfSel = cur_ff.perfHigh;
    nxt_ff.muxSel = cur_ff.perfHigh;
    // Hold window outlasts the regulator slewing to its new code
    if (cur_ff.perfHigh != cur_ff.perfSel) begin
      nxt_ff.holdCnt = HOLD_W'(PERF_HOLD_CYC);
    end else if (cur_ff.holdCnt != '0) begin
      nxt_ff.holdCnt = cur_ff.holdCnt - HOLD_W'(1);
    end
    if (!cur_ff.pokLvl) begin
      nxt_ff.pwrGood = 1'b0;
    end else if (cur_ff.vgLvl) begin
      nxt_ff.pwrGood = 1'b1;
    end else if (cur_ff.holdCnt == '0 && sysState != ST_S1M &&
                 cur_ff.perfHigh == cur_ff.perfSel) begin
      nxt_ff.pwrGood = 1'b0;
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // One wait state: ack rises the cycle after the request and drops after
    access = cyc_i && stb_i && !cur_ff.ack;
    nxt_ff.ack = access;
    // Only byte lane zero carries fields, so sel_i[0] gates writes
    wrCtrl = access && we_i && sel_i[0] && (adr_i == ADDR_CTRL);
    wrMask = access && we_i && sel_i[0] && (adr_i == ADDR_MASK);
    rdStatus = access && !we_i && (adr_i == ADDR_STATUS);
    if (wrCtrl) begin
      nxt_ff.throttleEnable = dat_i[CTRL_THR_EN];
      nxt_ff.throttleDuty = dat_i[CTRL_DUTY_LSB +: DUTY_W];
      nxt_ff.perfHigh = dat_i[CTRL_PERF_HIGH];
      nxt_ff.sciRoutingEnable = dat_i[CTRL_SCI_ROUTING_ENABLE];
      nxt_ff.ringWakeEnable = dat_i[CTRL_RING_EN];
    end
    if (wrMask) begin
      nxt_ff.mask = dat_i[EV_W-1:0];
    end
    // Zero outside the ack cycle; unmapped offsets read zero
    nxt_ff.rdata = DATA_ZERO;
    if (access && !we_i) begin
      case (adr_i)
        ADDR_CTRL: begin
          nxt_ff.rdata[CTRL_THR_EN] = cur_ff.throttleEnable;
          nxt_ff.rdata[CTRL_DUTY_LSB +: DUTY_W] = cur_ff.throttleDuty;
          nxt_ff.rdata[CTRL_PERF_HIGH] = cur_ff.perfHigh;
          nxt_ff.rdata[CTRL_SCI_ROUTING_ENABLE] = cur_ff.sciRoutingEnable;
          nxt_ff.rdata[CTRL_RING_EN] = cur_ff.ringWakeEnable;
        end
        ADDR_STATUS: begin
          nxt_ff.rdata[EV_W-1:0] = cur_ff.status;
        end
        ADDR_MASK: begin
          nxt_ff.rdata[EV_W-1:0] = cur_ff.mask;
        end
        ADDR_LEVEL: begin
          nxt_ff.rdata[LVL_BUTTON] = cur_ff.btnDb;
          nxt_ff.rdata[LVL_PERF] = cur_ff.perfSel;
          nxt_ff.rdata[LVL_MUX] = cur_ff.muxSel;
          nxt_ff.rdata[LVL_PWRGOOD] = cur_ff.pwrGood;
          nxt_ff.rdata[LVL_STOPCLK_N] = cur_ff.stopClkN;
        end
        default: begin
          nxt_ff.rdata = DATA_ZERO;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Sticky status and interrupt
    // ----------------------------------------------------------------
    // Read clears, but an event in the same cycle survives
    for (int i = 0; i < EV_W; i++) begin
      nxtStatus[i] = evSet[i] || (cur_ff.status[i] && !rdStatus);
    end
    nxt_ff.status = nxtStatus;
    nxt_ff.irqOut = |(nxtStatus & nxt_ff.mask);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.stopClkN <= 1'b1;
      // Mask clear so no interrupt before software opts in
      cur_ff.mask <= MASK_RESET;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o = cur_ff.rdata;
  assign ack_o = cur_ff.ack;
  assign stopClockN = cur_ff.stopClkN;
  assign cpuPerformanceSelect = cur_ff.perfSel;
  assign voltageMuxSelect = cur_ff.muxSel;
  assign cpuPowerGood = cur_ff.pwrGood;
  assign wakeEvent = cur_ff.wake;
  assign smiEvent = cur_ff.smi;
  assign sciEvent = cur_ff.sci;
  assign forceS5 = cur_ff.s5;
  assign irq = cur_ff.irqOut;

endmodule : power_event_ctrl

`default_nettype wire

// ### src/pwr_event_pkg.sv
// Constants and types for the power event and performance state controller.
// Assumes a 100 MHz mclk and a classic Wishbone master with 32-bit data.
package pwr_event_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CNT_W = 29;
  localparam int unsigned DEBOUNCE_MS = 16;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned OVERRIDE_S = 4;
  localparam int unsigned OVERRIDE_CYC = OVERRIDE_S * CLK_HZ;
  localparam int unsigned PERF_HOLD_US = 20;
  localparam int unsigned PERF_HOLD_CYC = PERF_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOLD_W = 12;

  // Throttle period of 1024 cycles split in eight duty steps
  localparam int unsigned THR_W = 10;
  localparam logic [THR_W-1:0] THR_STEP = 10'h080;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_LEVEL = 4'hC;

  // CTRL fields
  localparam int unsigned CTRL_THR_EN = 0;
  localparam int unsigned CTRL_DUTY_LSB = 1;
  localparam int unsigned DUTY_W = 3;
  localparam int unsigned CTRL_PERF_HIGH = 4;
  localparam int unsigned CTRL_SCI_ROUTING_ENABLE = 5;
  localparam int unsigned CTRL_RING_EN = 6;

  // STATUS and MASK fields
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_BUTTON = 0;
  localparam int unsigned EV_OVERRIDE = 1;
  localparam int unsigned EV_RING_BREAK = 2;
  localparam int unsigned EV_RING_WAKE = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  // LEVEL fields
  localparam int unsigned LVL_BUTTON = 0;
  localparam int unsigned LVL_PERF = 1;
  localparam int unsigned LVL_MUX = 2;
  localparam int unsigned LVL_PWRGOOD = 3;
  localparam int unsigned LVL_STOPCLK_N = 4;

  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // System sleep state reported by the sleep machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_S0,
    ST_S1M,
    ST_S3,
    ST_S4,
    ST_S5,
    ST_G3
  } sys_state_t;

endpackage : pwr_event_pkg

// ### bench/power_event_chk.sv
// Port checker for the power event controller.
// Assumes a bind from the bench top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module power_event_chk
  import pwr_event_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
  parameter logic [CNT_W-1:0] OVERRIDE_CYCLES = CNT_W'(OVERRIDE_CYC)
) (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Inputs of the block
  input wire sys_state_t sysState,
  input wire logic powerButtonN,
  input wire logic powerOk,
  // Outputs of the block
  input wire logic cpuPerformanceSelect,
  input wire logic voltageMuxSelect,
  input wire logic cpuPowerGood,
  input wire logic wakeEvent,
  input wire logic smiEvent,
  input wire logic sciEvent,
  input wire logic forceS5
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Runs of a low pin; the S0 run restarts on leaving S0
  logic [31:0] lowCnt_ff;
  logic [31:0] s0LowCnt_ff;
  always_ff @(posedge mclk) begin
    lowCnt_ff <= powerButtonN ? 32'h0000_0000 : lowCnt_ff + 32'h0000_0001;
    if (powerButtonN || sysState != ST_S0) begin
      s0LowCnt_ff <= 32'h0000_0000;
    end else begin
      s0LowCnt_ff <= s0LowCnt_ff + 32'h0000_0001;
    end
  end

  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_perf_mux_pair: assert property (cpuPerformanceSelect == voltageMuxSelect)
    else $error("mux select differs from perf select");
  a_good_over_switch: assert property ($changed(voltageMuxSelect) && cpuPowerGood && powerOk
    |=> cpuPowerGood [*8])
    else $error("power good dropped in perf switch");
  a_good_in_sleep: assert property (cpuPowerGood && powerOk && $past(powerOk, 3)
    && sysState == ST_S1M |=> cpuPowerGood)
    else $error("power good dropped in S1M");
  a_smi_only_s0: assert property (smiEvent || sciEvent |-> $past(sysState) == ST_S0)
    else $error("smi or sci outside S0");
  a_wake_sleep_only: assert property (wakeEvent
    |-> $past(sysState) inside {ST_S1M, ST_S3, ST_S4, ST_S5})
    else $error("wake outside sleep states");
  a_debounce_min: assert property (smiEvent || sciEvent
    |-> lowCnt_ff >= 32'(DEBOUNCE_CYCLES))
    else $error("press seen before debounce time");
  a_override_min: assert property (forceS5 |-> s0LowCnt_ff >= 32'(OVERRIDE_CYCLES))
    else $error("override before hold time in S0");
  a_override_once: assert property (forceS5 |=> !forceS5 [*8])
    else $error("override pulse repeated");
endmodule : power_event_chk
`default_nettype wire

// ### bench/pwr_far_side.sv
// Far-side model: power button, modem ring line and core regulator.
// Assumes bench requests change just after rising mclk edges.
`timescale 1ns/1ps
`default_nettype none
module pwr_far_side #(
  parameter int SLEW_CYC = 6
) (
  // Clock and bench requests
  input wire logic mclk,
  input wire logic pressReq,
  input wire logic ringReq,
  input wire logic sagReq,
  // Device pins
  input wire logic voltageMuxSelect,
  output logic powerButtonN,
  output logic ringIndicateN,
  output logic regulatorGood
);
  logic lastMux = 1'b0;
  int slewCnt = 0;
  // Button pulls up when released
  assign powerButtonN = !pressReq;
  // modem hands over a clean, already filtered ring level
  assign ringIndicateN = !ringReq;
  // Regulator leaves spec while slewing to a new code
  always @(posedge mclk) begin
    if (voltageMuxSelect !== lastMux) begin
      slewCnt <= SLEW_CYC;
    end else if (slewCnt > 0) begin
      slewCnt <= slewCnt - 1;
    end
    lastMux <= voltageMuxSelect;
  end
  // Bench can sag the regulator to probe the power good hold
  assign regulatorGood = (slewCnt == 0) && !sagReq;
endmodule : pwr_far_side
`default_nettype wire

// ### bench/power_event_ctrl_test.sv
// Self-checking bench for the power event controller.
// Assumes short debounce and override counts and the far-side model.
`timescale 1ns/1ps
`default_nettype none
module power_event_ctrl_test
  import pwr_event_pkg::*;
;
  localparam logic [CNT_W-1:0] DEB = 29'h0000_0014;
  localparam logic [CNT_W-1:0] OVR = 29'h0000_0032;
  logic mclk, sys_rst, cyc_i, stb_i, we_i, ack_o, powerOk, pressReq, ringReq, sagReq, p;
  logic powerButtonN, ringIndicateN, regulatorGood, stopClockN, cpuPerformanceSelect;
  logic voltageMuxSelect, cpuPowerGood, wakeEvent, smiEvent, sciEvent, forceS5, irq;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd, mv;
  sys_state_t sysState;
  int error_cnt, tests_run;
  int evCnt [4];

  power_event_ctrl #(.DEBOUNCE_CYCLES(DEB), .OVERRIDE_CYCLES(OVR)) DUT (.mclk, .sys_rst,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sysState, .powerButtonN,
    .ringIndicateN, .powerOk, .regulatorGood, .stopClockN, .cpuPerformanceSelect,
    .voltageMuxSelect, .cpuPowerGood, .wakeEvent, .smiEvent, .sciEvent, .forceS5, .irq);
  pwr_far_side far (.mclk, .pressReq, .ringReq, .sagReq, .voltageMuxSelect, .powerButtonN,
    .ringIndicateN, .regulatorGood);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Event tallies: wake, smi, sci, override
  always @(posedge mclk) begin
    evCnt[0] <= evCnt[0] + int'(wakeEvent === 1'b1);
    evCnt[1] <= evCnt[1] + int'(smiEvent === 1'b1);
    evCnt[2] <= evCnt[2] + int'(sciEvent === 1'b1);
    evCnt[3] <= evCnt[3] + int'(forceS5 === 1'b1);
  end

  task automatic report_and_stop;
    $display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  // Classic cycle; read data taken at the ack edge only
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    sel_i <= 4'hF;
    adr_i <= adr;
    dat_i <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    @(posedge mclk);
  endtask : wb
  // Expected {override, sci, smi, wake} for one press
  function automatic logic [3:0] press_exp(sys_state_t st, logic sci, int len);
    if (st == ST_G3 || len < int'(DEB)) return 4'h0;
    if (st != ST_S0) return 4'h1;
    return {len > int'(DEB + OVR), sci, !sci, 1'b0};
  endfunction : press_exp
  task automatic press(input sys_state_t st, input int len, input logic sci);
    int b [4];
    logic [3:0] e;
    e = press_exp(st, sci, len);
    sysState <= st;
    b = evCnt;
    pressReq <= 1'b1;
    idle(len);
    pressReq <= 1'b0;
    idle(int'(DEB) + 12);
    for (int i = 0; i < 4; i++) chk(32'(evCnt[i] - b[i]), 32'(e[i]));
  endtask : press
  task automatic ring(input sys_state_t st, input logic en, input logic m);
    int w;
    logic [3:0] e;
    e = (st == ST_S0) ? 4'h4 : (en ? 4'h8 : 4'h0);
    wb(1'b1, ADDR_CTRL, 32'(en) << CTRL_RING_EN);
    wb(1'b1, ADDR_MASK, m ? 32'h0000_000F : DATA_ZERO);
    sysState <= st;
    w = evCnt[0];
    ringReq <= 1'b1;
    idle(3);
    ringReq <= 1'b0;
    idle(8);
    chk(32'(irq), 32'(m && e != 4'h0));
    chk(32'(evCnt[0] - w), 32'(e[3]));
    wb(1'b0, ADDR_STATUS, DATA_ZERO);
    chk(rd, 32'(e));
    idle(2);
    chk(32'(irq), 32'h0000_0000);
  endtask : ring
  task automatic throttle(input logic [2:0] d);
    int lowN;
    wb(1'b1, ADDR_CTRL, 32'({d, 1'b1}));
    idle(1030);
    lowN = 0;
    repeat (1024) begin
      @(posedge mclk);
      lowN += int'(stopClockN === 1'b0);
    end
    chk(32'(lowN), 32'(d) * 32'(THR_STEP));
  endtask : throttle

  initial begin
    {sys_rst, powerOk} = 2'b11;
    {cyc_i, stb_i, we_i, pressReq, ringReq, sagReq} = 6'h00;
    {adr_i, dat_i, sel_i} = {4'h0, DATA_ZERO, 4'hF};
    sysState = ST_S0;
    evCnt = '{0, 0, 0, 0};
    error_cnt = 0;
    tests_run = 0;
    rd = $urandom(32'h564e_d63f);
    idle(4);
    sys_rst <= 1'b0;
    idle(8);
    wb(1'b0, ADDR_CTRL, DATA_ZERO);
    chk(rd, DATA_ZERO);
    wb(1'b0, ADDR_LEVEL, DATA_ZERO);
    chk(rd, 32'h0000_0018);
    wb(1'b1, 4'h2, 32'hFFFF_FFFF);
    wb(1'b0, 4'h2, DATA_ZERO);
    chk(rd, DATA_ZERO);
    mv = 32'($urandom % 16);
    wb(1'b1, ADDR_MASK, mv);
    wb(1'b0, ADDR_MASK, DATA_ZERO);
    chk(rd, mv);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 1'b1 : 1'($urandom);
      wb(1'b1, ADDR_CTRL, 32'(p) << CTRL_PERF_HIGH);
      idle(5);
      chk(32'(cpuPowerGood), 32'h0000_0001);
      idle(8);
      chk(32'(cpuPerformanceSelect), 32'(p));
      chk(32'(voltageMuxSelect), 32'(p));
    end
    for (int d = 0; d < 8; d++) throttle(3'(d));
    $display("test perf and throttle done");
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, ADDR_CTRL, 32'(s) << CTRL_SCI_ROUTING_ENABLE);
      press(ST_S0, 30, 1'(s));
    end
    press(ST_S0, 10, 1'b1);
    pressReq <= 1'b1;
    idle(int'(DEB) + 8);
    wb(1'b0, ADDR_LEVEL, DATA_ZERO);
    chk(32'(rd[LVL_BUTTON]), 32'h0000_0001);
    pressReq <= 1'b0;
    idle(int'(DEB) + 12);
    wb(1'b0, ADDR_STATUS, DATA_ZERO);
    for (int i = 0; i < 3; i++) press(sys_state_t'(3'(1 + $urandom % 4)), 30, 1'b1);
    wb(1'b0, ADDR_STATUS, DATA_ZERO);
    chk(rd, 32'h0000_0001);
    press(ST_S1M, 30, 1'b1);
    sagReq <= 1'b1;
    idle(20);
    chk(32'(cpuPowerGood), 32'h0000_0001);
    sysState <= ST_S0;
    idle(20);
    chk(32'(cpuPowerGood), 32'h0000_0000);
    sagReq <= 1'b0;
    idle(10);
    wb(1'b0, ADDR_STATUS, DATA_ZERO);
    press(ST_G3, 30, 1'b1);
    wb(1'b0, ADDR_STATUS, DATA_ZERO);
    chk(rd, DATA_ZERO);
    press(ST_S3, 90, 1'b1);
    powerOk <= 1'b0;
    press(ST_S0, 90, 1'b1);
    powerOk <= 1'b1;
    idle(10);
    wb(1'b0, ADDR_STATUS, DATA_ZERO);
    $display("test button done");
    ring(ST_S0, 1'b1, 1'b1);
    ring(sys_state_t'(3'(1 + $urandom % 4)), 1'b0, 1'b1);
    ring(ST_S4, 1'b1, 1'b1);
    ring(ST_S0, 1'b0, 1'b0);
    $display("test ring done");
    report_and_stop();
  end
endmodule : power_event_ctrl_test

bind power_event_ctrl power_event_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .OVERRIDE_CYCLES(OVERRIDE_CYCLES)) chk_i (.mclk, .sys_rst, .cyc_i, .stb_i, .ack_o,
  .sysState, .powerButtonN, .powerOk, .cpuPerformanceSelect, .voltageMuxSelect,
  .cpuPowerGood, .wakeEvent, .smiEvent, .sciEvent, .forceS5);
`default_nettype wire
